// file: design/lmfbc_map.svh
// register offsets, field positions, reset values, write masks and bus response codes for the config bank
// ----------------------------------------------------------------------------
// Summary of operation
// - Open-load thresholds are 2 bits per colour (red 1-0, green 3-2, blue 5-4), reset 0.
// - Bit 7 of the first register, reset 0, turns the fault readback function off (0) or on (1).
// - Colour gains are 8 bits (red 15-8, green 23-16, blue 31-24), reset 127, linear.
// - Global brightness is 3 bits in 34-32, reset 3, eight levels from 0 up to 7.
// - Short removal strength is bits 38-35 of the first register, reset 7, level n+1.
// - Red short threshold sits in bits 41-39, reset 0, codes selecting 0.2 V up to 1.8 V.
// - Green and blue short thresholds are bits 44-42 and 47-45, reset 0, 0.2 V to 2.8 V.
// - Bit 1 of the second register, reset 0, picks a 10 mA (0) or 20 mA (1) channel ceiling.
// - Bit 14 of the second register, reset 1, reverses the scan order of lines 16-31 when set.
// - Bits 16, 17, 18, reset 0, enable the fine compensation range for red, green, blue.
// - Bits 19, 20, 21, reset 0, pick slow (0) or fast (1) turn-off edges for red, green, blue.
// - Turn-on edges are 2 bits (red 23-22, green 25-24, blue 27-26), reset 1, slow to fast.
// - Bits 32, 33, 34, reset 0, enable the coarse compensation range for red, green, blue.
// - First-line dimming sits in bits 38-35 of the second register, reset 0, level n+1.
// - Bit 39 of the second register, reset 0, enables on/off channel isolation.
// - Isolation boost level is bits 43-40, reset 8, acting only while bit 44, reset 0, is set.
// ----------------------------------------------------------------------------
`ifndef LMFBC_MAP_SVH
`define LMFBC_MAP_SVH

// ----------------------------------------------------------------------------
// word offsets: each 48-bit register spans a low and a high word
// ----------------------------------------------------------------------------
`define LMFBC_OFF_FB_LO 4'h0
`define LMFBC_OFF_FB_HI 4'h4
`define LMFBC_OFF_DC_LO 4'h8
`define LMFBC_OFF_DC_HI 4'hC

// ----------------------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------------------
`define LMFBC_FB_WMASK 48'hFFFF_FFFF_FFBF
`define LMFBC_FB_RESET 48'h003B_7F7F_7F00
`define LMFBC_DC_WMASK 48'h1FFF_0FFF_4002
`define LMFBC_DC_RESET 48'h0800_0540_403C

// ----------------------------------------------------------------------------
// field positions, first register
// ----------------------------------------------------------------------------
`define LMFBC_OPEN_R_LSB 0
`define LMFBC_OPEN_G_LSB 2
`define LMFBC_OPEN_B_LSB 4
`define LMFBC_RB_EN_BIT 7
`define LMFBC_GAIN_R_LSB 8
`define LMFBC_GAIN_G_LSB 16
`define LMFBC_GAIN_B_LSB 24
`define LMFBC_GLOBAL_LSB 32
`define LMFBC_RM_LSB 35
`define LMFBC_SHORT_R_LSB 39
`define LMFBC_SHORT_G_LSB 42
`define LMFBC_SHORT_B_LSB 45

// ----------------------------------------------------------------------------
// field positions, second register
// ----------------------------------------------------------------------------
`define LMFBC_CEIL_BIT 1
`define LMFBC_REV_BIT 14
`define LMFBC_FINE_LSB 16
`define LMFBC_OFF_EDGE_LSB 19
`define LMFBC_ON_R_LSB 22
`define LMFBC_ON_G_LSB 24
`define LMFBC_ON_B_LSB 26
`define LMFBC_COARSE_LSB 32
`define LMFBC_DIM_LSB 35
`define LMFBC_ISO_EN_BIT 39
`define LMFBC_BOOST_LSB 40
`define LMFBC_BOOST_EN_BIT 44

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define LMFBC_RESP_OKAY 2'h0
`define LMFBC_RESP_SLVERR 2'h2

`endif

// file: design/lmfbc_pkg.sv
// types shared by the config bank modules
package lmfbc_pkg;
  typedef logic [47:0] lmfbc_word48_t;
  typedef enum logic [1:0] {
    LMFBC_W_IDLE = 2'b00,
    LMFBC_W_RESP = 2'b01
  } lmfbc_wstate_t;
endpackage

// file: design/lmfbc_store_if.sv
// write-port bundle between the bus slave and the register store
`timescale 1ns/1ps
interface lmfbc_store_if;
  logic we;
  logic [1:0] sel;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  lmfbc_pkg::lmfbc_word48_t fb;
  lmfbc_pkg::lmfbc_word48_t dc;
  modport ctrl (output we, output sel, output wdata, output wstrb, input fb, input dc);
  modport store (input we, input sel, input wdata, input wstrb, output fb, output dc);
endinterface

// file: design/lmfbc_store.sv
// the two 48-bit configuration registers with masked byte writes
`timescale 1ns/1ps
`include "lmfbc_map.svh"
module lmfbc_store (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write port
  lmfbc_store_if.store sp
);
  lmfbc_pkg::lmfbc_word48_t fb;
  lmfbc_pkg::lmfbc_word48_t dc;
  lmfbc_pkg::lmfbc_word48_t next_fb;
  lmfbc_pkg::lmfbc_word48_t next_dc;

  // spread strobes over a 48-bit word; high word only has two live bytes
  function automatic lmfbc_pkg::lmfbc_word48_t lane_mask(input logic hi, input logic [3:0] s);
    lmfbc_pkg::lmfbc_word48_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        if (hi) begin
          if (i < 2) begin
            m[32 + 8 * i +: 8] = 8'hFF;
          end
        end else begin
          m[8 * i +: 8] = 8'hFF;
        end
      end
    end
    return m;
  endfunction

  wire lmfbc_pkg::lmfbc_word48_t lanes = lane_mask(sp.sel[0], sp.wstrb);
  wire lmfbc_pkg::lmfbc_word48_t wide = {sp.wdata[15:0], sp.wdata};
  // reserved bits stay out of the write mask, so they never move
  wire lmfbc_pkg::lmfbc_word48_t fb_m = lanes & `LMFBC_FB_WMASK;
  wire lmfbc_pkg::lmfbc_word48_t dc_m = lanes & `LMFBC_DC_WMASK;
  wire fb_we = sp.we && !sp.sel[1];
  wire dc_we = sp.we && sp.sel[1];

  assign next_fb = fb_we ? ((fb & ~fb_m) | (wide & fb_m)) : fb;
  assign next_dc = dc_we ? ((dc & ~dc_m) | (wide & dc_m)) : dc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb <= `LMFBC_FB_RESET;
      dc <= `LMFBC_DC_RESET;
    end else begin
      fb <= next_fb;
      dc <= next_dc;
    end
  end

  assign sp.fb = fb;
  assign sp.dc = dc;
endmodule

// file: design/lmfbc_top.sv
// AXI4-Lite slave holding the fault/brightness and drive/compensation config registers
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "lmfbc_map.svh"
module lmfbc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // open-load thresholds
  output logic [1:0] open_thresh_red,
  output logic [1:0] open_thresh_green,
  output logic [1:0] open_thresh_blue,
  // fault readback
  output logic fault_readback_enable,
  // brightness
  output logic [7:0] color_gain_red,
  output logic [7:0] color_gain_green,
  output logic [7:0] color_gain_blue,
  output logic [2:0] global_brightness,
  // short handling
  output logic [3:0] short_removal_level,
  output logic [2:0] short_thresh_red,
  output logic [2:0] short_thresh_green,
  output logic [2:0] short_thresh_blue,
  // drive
  output logic channel_current_ceiling,
  output logic upper_lines_reverse,
  output logic [2:0] fine_range_enable,
  output logic [2:0] coarse_range_enable,
  output logic turnoff_edge_red,
  output logic turnoff_edge_green,
  output logic turnoff_edge_blue,
  output logic [1:0] turnon_edge_red,
  output logic [1:0] turnon_edge_green,
  output logic [1:0] turnon_edge_blue,
  // dimming and isolation
  output logic [3:0] first_line_dim_level,
  output logic on_off_isolation_enable,
  output logic [3:0] isolation_boost_level,
  output logic isolation_boost_enable,
  output logic [3:0] isolation_boost_applied
);
  // --------------------------------------------------------------------------
  // register store
  // --------------------------------------------------------------------------
  lmfbc_store_if sp ();
  lmfbc_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .sp(sp)
  );

  // --------------------------------------------------------------------------
  // decoding
  // --------------------------------------------------------------------------
  // all four word offsets are mapped; anything else answers with an error
  function automatic logic addr_hit(input logic [3:0] a);
    return (a[1:0] == 2'h0);
  endfunction

  // --------------------------------------------------------------------------
  // write path: address and data caught in either order, answered together
  // --------------------------------------------------------------------------
  lmfbc_pkg::lmfbc_wstate_t wstate;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] bresp;
  logic bvalid;

  wire aw_take = s_axi_awvalid && !aw_held && (wstate == lmfbc_pkg::LMFBC_W_IDLE);
  wire w_take = s_axi_wvalid && !w_held && (wstate == lmfbc_pkg::LMFBC_W_IDLE);
  wire aw_have = aw_held || aw_take;
  wire w_have = w_held || w_take;
  wire [3:0] eff_awaddr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] eff_wdata = w_held ? w_data : s_axi_wdata;
  wire [3:0] eff_wstrb = w_held ? w_strb : s_axi_wstrb;
  wire do_write = (wstate == lmfbc_pkg::LMFBC_W_IDLE) && aw_have && w_have;
  wire wr_ok = addr_hit(eff_awaddr);

  assign sp.we = do_write && wr_ok;
  assign sp.sel = eff_awaddr[3:2];
  assign sp.wdata = eff_wdata;
  assign sp.wstrb = eff_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= lmfbc_pkg::LMFBC_W_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bresp <= `LMFBC_RESP_OKAY;
      bvalid <= 1'b0;
    end else begin
      case (wstate)
        lmfbc_pkg::LMFBC_W_IDLE: begin
          if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? `LMFBC_RESP_OKAY : `LMFBC_RESP_SLVERR;
            wstate <= lmfbc_pkg::LMFBC_W_RESP;
          end else begin
            if (aw_take) begin
              aw_held <= 1'b1;
              aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
              w_held <= 1'b1;
              w_data <= s_axi_wdata;
              w_strb <= s_axi_wstrb;
            end
          end
        end
        lmfbc_pkg::LMFBC_W_RESP: begin
          if (s_axi_bready) begin
            bvalid <= 1'b0;
            wstate <= lmfbc_pkg::LMFBC_W_IDLE;
          end
        end
        default: begin
          wstate <= lmfbc_pkg::LMFBC_W_IDLE;
          bvalid <= 1'b0;
        end
      endcase
    end
  end

  assign s_axi_awready = (wstate == lmfbc_pkg::LMFBC_W_IDLE) && !aw_held;
  assign s_axi_wready = (wstate == lmfbc_pkg::LMFBC_W_IDLE) && !w_held;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // --------------------------------------------------------------------------
  // read path: one read at a time, data registered one cycle after address
  // --------------------------------------------------------------------------
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  wire ar_take = s_axi_arvalid && !rvalid;
  wire [31:0] rd_word;
  // reserved bits come straight from the store, which holds them fixed
  assign rd_word = (s_axi_araddr == `LMFBC_OFF_FB_LO) ? sp.fb[31:0] :
                   (s_axi_araddr == `LMFBC_OFF_FB_HI) ? {16'h0000, sp.fb[47:32]} :
                   (s_axi_araddr == `LMFBC_OFF_DC_LO) ? sp.dc[31:0] :
                   (s_axi_araddr == `LMFBC_OFF_DC_HI) ? {16'h0000, sp.dc[47:32]} :
                   32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `LMFBC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= addr_hit(s_axi_araddr) ? `LMFBC_RESP_OKAY : `LMFBC_RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // --------------------------------------------------------------------------
  // configuration outputs, registered one cycle behind the store
  // --------------------------------------------------------------------------
  wire lmfbc_pkg::lmfbc_word48_t fb = sp.fb;
  wire lmfbc_pkg::lmfbc_word48_t dc = sp.dc;
  // boost level is only passed on to isolation_boost_applied while its enable is set
  wire boost_on = dc[`LMFBC_BOOST_EN_BIT];
  wire [3:0] next_boost_applied = boost_on ? dc[`LMFBC_BOOST_LSB +: 4] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_thresh_red <= 2'h0;
      open_thresh_green <= 2'h0;
      open_thresh_blue <= 2'h0;
      fault_readback_enable <= 1'b0;
      color_gain_red <= 8'h7F;
      color_gain_green <= 8'h7F;
      color_gain_blue <= 8'h7F;
      global_brightness <= 3'h3;
      short_removal_level <= 4'h7;
      short_thresh_red <= 3'h0;
      short_thresh_green <= 3'h0;
      short_thresh_blue <= 3'h0;
      channel_current_ceiling <= 1'b0;
      upper_lines_reverse <= 1'b1;
      fine_range_enable <= 3'h0;
      coarse_range_enable <= 3'h0;
      turnoff_edge_red <= 1'b0;
      turnoff_edge_green <= 1'b0;
      turnoff_edge_blue <= 1'b0;
      turnon_edge_red <= 2'h1;
      turnon_edge_green <= 2'h1;
      turnon_edge_blue <= 2'h1;
      first_line_dim_level <= 4'h0;
      on_off_isolation_enable <= 1'b0;
      isolation_boost_level <= 4'h8;
      isolation_boost_enable <= 1'b0;
      isolation_boost_applied <= 4'h0;
    end else begin
      open_thresh_red <= fb[`LMFBC_OPEN_R_LSB +: 2];
      open_thresh_green <= fb[`LMFBC_OPEN_G_LSB +: 2];
      open_thresh_blue <= fb[`LMFBC_OPEN_B_LSB +: 2];
      fault_readback_enable <= fb[`LMFBC_RB_EN_BIT];
      color_gain_red <= fb[`LMFBC_GAIN_R_LSB +: 8];
      color_gain_green <= fb[`LMFBC_GAIN_G_LSB +: 8];
      color_gain_blue <= fb[`LMFBC_GAIN_B_LSB +: 8];
      global_brightness <= fb[`LMFBC_GLOBAL_LSB +: 3];
      short_removal_level <= fb[`LMFBC_RM_LSB +: 4];
      short_thresh_red <= fb[`LMFBC_SHORT_R_LSB +: 3];
      short_thresh_green <= fb[`LMFBC_SHORT_G_LSB +: 3];
      short_thresh_blue <= fb[`LMFBC_SHORT_B_LSB +: 3];
      channel_current_ceiling <= dc[`LMFBC_CEIL_BIT];
      upper_lines_reverse <= dc[`LMFBC_REV_BIT];
      fine_range_enable <= dc[`LMFBC_FINE_LSB +: 3];
      coarse_range_enable <= dc[`LMFBC_COARSE_LSB +: 3];
      turnoff_edge_red <= dc[`LMFBC_OFF_EDGE_LSB];
      turnoff_edge_green <= dc[`LMFBC_OFF_EDGE_LSB + 1];
      turnoff_edge_blue <= dc[`LMFBC_OFF_EDGE_LSB + 2];
      turnon_edge_red <= dc[`LMFBC_ON_R_LSB +: 2];
      turnon_edge_green <= dc[`LMFBC_ON_G_LSB +: 2];
      turnon_edge_blue <= dc[`LMFBC_ON_B_LSB +: 2];
      first_line_dim_level <= dc[`LMFBC_DIM_LSB +: 4];
      on_off_isolation_enable <= dc[`LMFBC_ISO_EN_BIT];
      isolation_boost_level <= dc[`LMFBC_BOOST_LSB +: 4];
      isolation_boost_enable <= boost_on;
      isolation_boost_applied <= next_boost_applied;
    end
  end
endmodule

// file: test/lmfbc_props.sv
// concurrent checks on the config bank's bus handshakes and field outputs
`timescale 1ns/1ps
module lmfbc_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fields
  input wire logic fault_readback_enable,
  input wire logic [7:0] color_gain_red,
  input wire logic [7:0] color_gain_blue,
  input wire logic [2:0] global_brightness,
  input wire logic [3:0] short_removal_level,
  input wire logic upper_lines_reverse,
  input wire logic [3:0] isolation_boost_level,
  input wire logic isolation_boost_enable,
  input wire logic [3:0] isolation_boost_applied
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------------------------------------------------------------
  // helper logic
  // --------------------------------------------------------------------------
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire [1:0] aw_low = s_axi_awaddr[1:0];
  wire [1:0] ar_low = s_axi_araddr[1:0];
  // only fields reachable from these ports; enough to catch a stray update
  wire [28:0] cfg_view = {fault_readback_enable, color_gain_red, color_gain_blue,
    global_brightness, short_removal_level, upper_lines_reverse, isolation_boost_level};
  logic [3:0] rd_addr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr <= 4'h0;
    end else if (rd_take) begin
      rd_addr <= s_axi_araddr;
    end
  end
  sequence s_wr_taken;
    wr_take;
  endsequence
  sequence s_wr_answered;
    ##1 s_axi_bvalid;
  endsequence
  // --------------------------------------------------------------------------
  // bus behaviour
  // --------------------------------------------------------------------------
  wr_answer_a:
    assert property (s_wr_taken |-> s_wr_answered)
    else $error("write response missing one cycle after the write was taken");
  bresp_code_a:
    assert property (s_wr_taken |=> s_axi_bresp == (($past(aw_low) != 2'h0) ? 2'h2 : 2'h0))
    else $error("write response code does not match the address alignment");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before it was accepted");
  busy_refuse_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while a response is pending");
  rd_answer_a:
    assert property (rd_take |=> s_axi_rvalid
      && s_axi_rresp == (($past(ar_low) != 2'h0) ? 2'h2 : 2'h0))
    else $error("read answer late or with the wrong response code");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before it was accepted");
  // --------------------------------------------------------------------------
  // fields
  // --------------------------------------------------------------------------
  reset_fields_a:
    assert property ($rose(aresetn) |-> (global_brightness == 3'h3 && short_removal_level == 4'h7
      && upper_lines_reverse && isolation_boost_level == 4'h8 && color_gain_red == 8'h7F) [*2])
    else $error("field outputs not at their reset values after reset");
  boost_gate_a:
    assert property (isolation_boost_applied ==
      (isolation_boost_enable ? isolation_boost_level : 4'h0))
    else $error("applied boost level does not follow its enable");
  cfg_quiet_a:
    assert property ($changed(cfg_view) |-> $past(wr_take, 2))
    else $error("field output changed without a write two cycles before");
  fb_map_a:
    assert property (s_axi_rvalid && rd_addr == 4'h0 |-> s_axi_rdata[7] == fault_readback_enable
      && s_axi_rdata[15:8] == color_gain_red && s_axi_rdata[31:24] == color_gain_blue)
    else $error("low word of the first register disagrees with its field outputs");
  fb_high_map_a:
    assert property (s_axi_rvalid && rd_addr == 4'h4 |->
      s_axi_rdata[6:0] == {short_removal_level, global_brightness})
    else $error("high word of the first register disagrees with its field outputs");
  dc_high_map_a:
    assert property (s_axi_rvalid && rd_addr == 4'hC |->
      s_axi_rdata[12:8] == {isolation_boost_enable, isolation_boost_level})
    else $error("high word of the second register disagrees with its field outputs");
endmodule

bind lmfbc_top lmfbc_props u_props (.*);

// file: test/tb_led_matrix_fault_brightness_cfg.sv
// self-checking bench for the config bank over its register bus
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected %s: expected %0h seen %0h", what, (exp), (got)); \
    end \
  end
module tb_led_matrix_fault_brightness_cfg;
  logic aclk, aresetn;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, open_thresh_red, open_thresh_green, open_thresh_blue;
  logic [1:0] turnon_edge_red, turnon_edge_green, turnon_edge_blue;
  logic [7:0] color_gain_red, color_gain_green, color_gain_blue;
  logic [2:0] global_brightness, short_thresh_red, short_thresh_green, short_thresh_blue;
  logic [2:0] fine_range_enable, coarse_range_enable;
  logic [3:0] short_removal_level, first_line_dim_level, isolation_boost_level;
  logic [3:0] isolation_boost_applied;
  logic fault_readback_enable, channel_current_ceiling, upper_lines_reverse;
  logic turnoff_edge_red, turnoff_edge_green, turnoff_edge_blue;
  logic on_off_isolation_enable, isolation_boost_enable;
  int compares = 0;
  int n_mismatch = 0;
  lmfbc_top u_dut (.*);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // --------------------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------------------
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // no new write may be taken while the answer is pending
    `CHK("write busy", 1'b0, s_axi_awready)
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK("read busy", 1'b0, s_axi_arready)
  endtask
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hF, r);
    `CHK("write resp", 2'h0, r)
  endtask
  task automatic get(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK("read resp", 2'h0, r)
    `CHK("read word", exp, d)
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_check();
    get(4'h0, 32'h7F7F_7F00);
    get(4'h4, 32'h0000_003B);
    get(4'h8, 32'h0540_403C);
    get(4'hC, 32'h0000_0800);
    `CHK("reset boost", 8'h80, {isolation_boost_level, isolation_boost_applied})
  endtask
  task automatic t_fb_pattern(input logic [47:0] v);
    put(4'h0, v[31:0]);
    put(4'h4, {16'hFFFF, v[47:32]});
    get(4'h0, v[31:0] & 32'hFFFF_FFBF);
    get(4'h4, {16'h0, v[47:32]});
    `CHK("open thr", v[5:0], {open_thresh_blue, open_thresh_green, open_thresh_red})
    `CHK("readback en", v[7], fault_readback_enable)
    `CHK("gains", v[31:8], {color_gain_blue, color_gain_green, color_gain_red})
    `CHK("global removal", v[38:32], {short_removal_level, global_brightness})
    `CHK("short thr", v[47:39],
      {short_thresh_blue, short_thresh_green, short_thresh_red})
  endtask
  task automatic t_dc_pattern(input logic [47:0] v);
    put(4'h8, v[31:0]);
    put(4'hC, {16'hFFFF, v[47:32]});
    get(4'h8, (v[31:0] & 32'h0FFF_4002) | 32'h0000_003C);
    get(4'hC, {19'h0, v[44:32]});
    `CHK("ceil rev", {v[14], v[1]}, {upper_lines_reverse, channel_current_ceiling})
    `CHK("fine", v[18:16], fine_range_enable)
    `CHK("off edge", v[21:19], {turnoff_edge_blue, turnoff_edge_green, turnoff_edge_red})
    `CHK("on edge", v[27:22], {turnon_edge_blue, turnon_edge_green, turnon_edge_red})
    `CHK("coarse dim", v[38:32], {first_line_dim_level, coarse_range_enable})
    `CHK("isolation", v[44:39],
      {isolation_boost_enable, isolation_boost_level, on_off_isolation_enable})
    `CHK("boost applied", (v[44] ? v[43:40] : 4'h0), isolation_boost_applied)
  endtask
  task automatic t_strobe_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    put(4'h0, 32'h0);
    axi_write(4'h0, 32'hFFFF_FFFF, 4'b0100, r);
    get(4'h0, 32'h00FF_0000);
    axi_write(4'h2, 32'hFFFF_FFFF, 4'hF, r);
    `CHK("unmapped wr resp", 2'h2, r)
    axi_read(4'h6, d, r);
    `CHK("unmapped rd", 34'h2_0000_0000, {r, d})
    get(4'h0, 32'h00FF_0000);
  endtask
  task automatic t_midreset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_check();
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_check();
    // repeated nibble walks every code of every field except the 8-bit gains across the loop
    for (int k = 0; k < 16; k++) begin
      t_fb_pattern({12{k[3:0]}});
      t_dc_pattern({12{k[3:0]}});
    end
    t_strobe_unmapped();
    t_midreset();
    final_report();
  end
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule
